//--- src/pwrmon_consts.vh
// register map, field layout and timing constants of the power monitor register bank
`ifndef PWRMON_CONSTS_VH
`define PWRMON_CONSTS_VH
`define PTR_CONFIG 8'h00
`define PTR_SHUNT 8'h01
`define PTR_BUS 8'h02
`define PTR_POWER 8'h03
`define PTR_CURRENT 8'h04
`define PTR_CAL 8'h05
`define CONFIG_RESET 16'h399f
`define CAL_RESET 16'h0000
`define RESULT_RESET 16'h0000
`define UNMAPPED_READ 16'h0000
`define CFG_RST_BIT 15
`define CFG_RANGE_BIT 13
`define CFG_GAIN_HI 12
`define CFG_GAIN_LO 11
`define CFG_BUS_CONVERSION_SETTING_HI 10
`define CFG_BUS_CONVERSION_SETTING_LO 7
`define CFG_SHUNT_CONVERSION_SETTING_HI 6
`define CFG_SHUNT_CONVERSION_SETTING_LO 3
`define CFG_MODE_HI 2
`define CFG_MODE_LO 0
`define MODE_CONT_BIT 2
`define MODE_BUS_BIT 1
`define MODE_SHUNT_BIT 0
`define WR_IDX_PTR 2'h0
`define WR_IDX_MSB 2'h1
`define WR_IDX_LSB 2'h2
`define WR_IDX_DONE 2'h3
`define BYTE_BITS 4'h8
`define DEFAULT_TARGET_ADDR 7'h40
`define CLK_PERIOD_NS 8
`define US_NS 1000
`define WRITE_SETTLE_NS 4000
`define SETTLE_CYCLES ((`WRITE_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define US_TICK_CYCLES (`US_NS / `CLK_PERIOD_NS)
`define SHUNT_FS_BASE 16'h0fa0
`define CONV_US_9B 17'h00054
`define CONV_US_10B 17'h00094
`define CONV_US_11B 17'h00114
`define CONV_US_12B 17'h00214
`define CONV_US_AVG2 17'h00424
`define CONV_US_AVG4 17'h00852
`define CONV_US_AVG8 17'h010a4
`define CONV_US_AVG16 17'h0213e
`define CONV_US_AVG32 17'h0427c
`define CONV_US_AVG64 17'h08502
`define CONV_US_AVG128 17'h10a04
`endif

//--- src/i2c_target_port.v
// serial target port: start/stop detection, address match, byte shifting and acknowledge
`timescale 1ns/1ps
`include "pwrmon_consts.vh"
module i2c_target_port #(
  parameter [6:0] TARGET_ADDR = `DEFAULT_TARGET_ADDR
) (
  input wire clk,
  input wire sys_rst,
  input wire scl_pin,
  input wire sda_pin,
  output reg sda_out,
  output reg sda_oe_n,
  output reg [7:0] rx_byte,
  output reg rx_valid,
  input wire [7:0] tx_byte,
  output reg tx_take,
  output reg txn_end
);
  localparam ST_IDLE = 3'h0, ST_ADDR = 3'h1, ST_ADDR_ACK = 3'h2, ST_WR = 3'h3;
  localparam ST_WR_ACK = 3'h4, ST_RD = 3'h5, ST_RD_ACK = 3'h6;
  reg [1:0] scl_sync;
  reg [1:0] sda_sync;
  reg scl_d;
  reg sda_d;
  reg [2:0] st;
  reg [7:0] sh;
  reg [3:0] cnt;
  reg rd;
  reg in_txn;
  wire scl_rise = scl_sync[1] & ~scl_d;
  wire scl_fall = ~scl_sync[1] & scl_d;
  wire start_c = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  wire stop_c = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
      tx_take <= 1'b0;
      txn_end <= 1'b0;
      st <= ST_IDLE;
      sh <= 8'h00;
      cnt <= 4'h0;
      rd <= 1'b0;
      in_txn <= 1'b0;
    end else begin
      scl_sync <= {scl_sync[0], scl_pin};
      sda_sync <= {sda_sync[0], sda_pin};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
      rx_valid <= 1'b0;
      tx_take <= 1'b0;
      txn_end <= 1'b0;
      if (start_c) begin
        st <= ST_ADDR;
        cnt <= 4'h0;
        sda_oe_n <= 1'b1;
        txn_end <= in_txn;
        in_txn <= 1'b1;
      end else if (stop_c) begin
        st <= ST_IDLE;
        sda_oe_n <= 1'b1;
        txn_end <= in_txn;
        in_txn <= 1'b0;
      end else begin
        case (st)
          ST_ADDR, ST_WR: begin
            if (scl_rise && cnt != `BYTE_BITS) begin
              sh <= {sh[6:0], sda_sync[1]};
              cnt <= cnt + 4'h1;
            end
            if (scl_fall && cnt == `BYTE_BITS) begin
              cnt <= 4'h0;
              if (st == ST_WR) begin
                rx_byte <= sh;
                rx_valid <= 1'b1;
                sda_oe_n <= 1'b0;
                st <= ST_WR_ACK;
              end else if (sh[7:1] == TARGET_ADDR) begin
                rd <= sh[0];
                sda_oe_n <= 1'b0;
                st <= ST_ADDR_ACK;
              end else begin
                st <= ST_IDLE;
              end
            end
          end
          ST_WR_ACK: begin
            if (scl_fall) begin
              sda_oe_n <= 1'b1;
              st <= ST_WR;
            end
          end
          ST_ADDR_ACK, ST_RD_ACK: begin
            if (scl_rise && st == ST_RD_ACK && sda_sync[1]) begin
              st <= ST_IDLE;
            end else if (scl_fall && (st == ST_RD_ACK || rd)) begin
              sh <= tx_byte;
              tx_take <= 1'b1;
              sda_oe_n <= tx_byte[7];
              cnt <= 4'h0;
              st <= ST_RD;
            end else if (scl_fall) begin
              sda_oe_n <= 1'b1;
              st <= ST_WR;
            end
          end
          ST_RD: begin
            if (scl_rise) begin
              cnt <= cnt + 4'h1;
            end
            if (scl_fall && cnt == `BYTE_BITS) begin
              sda_oe_n <= 1'b1;
              st <= ST_RD_ACK;
            end else if (scl_fall) begin
              sda_oe_n <= sh[6];
              sh <= {sh[6:0], 1'b0};
            end
          end
          default: st <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

//--- src/shunt_result_format.v
// clamps a raw shunt sample to the full scale of the selected gain
`timescale 1ns/1ps
`include "pwrmon_consts.vh"
module shunt_result_format (
  input wire [15:0] raw_sample,
  input wire [1:0] gain_select,
  output reg [15:0] formatted
);
  reg [15:0] limit;
  always @* begin
    limit = `SHUNT_FS_BASE << gain_select;
    if ($signed(raw_sample) > $signed(limit)) begin
      formatted = limit;
    end else if ($signed(raw_sample) < -$signed(limit)) begin
      formatted = 16'h0000 - limit;
    end else begin
      formatted = raw_sample;
    end
  end
endmodule

//--- src/power_monitor_register_bank.v
// register bank of the shunt current and power monitor behind its serial target port
// Overview of operation
// - a written value takes effect four microseconds after the write transaction ends; a second word arriving sooner commits it at once.
// - pointer 00 is the read/write configuration register, reset value 399f.
// - pointer 01 reads the latest shunt voltage result.
// - pointer 02 reads the latest bus voltage result.
// - power and current reset to zero and read zero while calibration is zero.
// - pointer 05 is the read/write calibration register, reset zero.
// - each 16-bit register travels as two bytes.
// - writing configuration bit 15 as one resets everything; the bit self-clears.
// - configuration bit 13 picks bus range, 16 V or 32 V, default 32 V.
// - configuration bits 12:11 pick shunt gain and range, default divide by eight.
// - configuration bits 10:7 set bus conversion resolution or averaging.
// - configuration bits 6:3 set shunt conversion resolution or averaging.
// - conversion code maps to 84 us up to 68.10 ms conversion time.
// - configuration bits 2:0 pick power-down, triggered, off or continuous conversion.
// - shunt result aligns to gain, all upper sign bits equal.
// - negative shunt results are two's complement, sign extended to 16 bits.
// - at divide by eight, full scale reads 7d00 and 8300, 10 uV steps.
// - the pointer stays put across reads until a write sets it.
// - words go most significant byte first.
`timescale 1ns/1ps
`include "pwrmon_consts.vh"
module power_monitor_register_bank #(
  parameter US_TICK_CYCLES = `US_TICK_CYCLES,
  parameter [6:0] TARGET_ADDR = `DEFAULT_TARGET_ADDR
) (
  input wire clk,
  input wire sys_rst,
  input wire scl_pin,
  input wire sda_pin,
  output wire sda_out,
  output wire sda_oe_n,
  input wire [15:0] shunt_sample,
  input wire [15:0] bus_sample,
  input wire [15:0] current_sample,
  input wire [15:0] power_sample,
  output wire bus_range_select,
  output wire [1:0] shunt_gain_select,
  output wire [3:0] bus_conversion_setting,
  output wire [3:0] shunt_conversion_setting,
  output wire [2:0] operating_mode,
  output wire [15:0] calibration_value,
  output wire shunt_convert,
  output wire bus_convert
);
  localparam SEQ_IDLE = 2'h0, SEQ_SHUNT = 2'h1, SEQ_BUS = 2'h2;
  localparam [31:0] SETTLE_FULL = `SETTLE_CYCLES - 1;
  localparam [31:0] TICK_FULL = US_TICK_CYCLES - 1;
  localparam [9:0] SETTLE_LAST = SETTLE_FULL[9:0];
  localparam [15:0] TICK_LAST = TICK_FULL[15:0];

  // conversion time in microseconds for a four-bit resolution/averaging code
  function [16:0] conv_us;
    input [3:0] code;
    begin
      if (!code[3]) begin
        case (code[1:0])
          2'h0: conv_us = `CONV_US_9B;
          2'h1: conv_us = `CONV_US_10B;
          2'h2: conv_us = `CONV_US_11B;
          default: conv_us = `CONV_US_12B;
        endcase
      end else begin
        case (code[2:0])
          3'h0: conv_us = `CONV_US_12B;
          3'h1: conv_us = `CONV_US_AVG2;
          3'h2: conv_us = `CONV_US_AVG4;
          3'h3: conv_us = `CONV_US_AVG8;
          3'h4: conv_us = `CONV_US_AVG16;
          3'h5: conv_us = `CONV_US_AVG32;
          3'h6: conv_us = `CONV_US_AVG64;
          default: conv_us = `CONV_US_AVG128;
        endcase
      end
    end
  endfunction

  reg [15:0] config_q;
  reg [15:0] cal_q;
  reg [15:0] shunt_q;
  reg [15:0] bus_q;
  reg [15:0] power_q;
  reg [15:0] current_q;
  reg [7:0] ptr_q;
  reg [1:0] wr_idx_q;
  reg [7:0] msb_q;
  reg [15:0] stage_q;
  reg [7:0] stage_ptr_q;
  reg stage_full_q;
  reg armed_q;
  reg [9:0] settle_q;
  reg soft_rst_q;
  reg rd_sel_q;
  reg [7:0] rd_lsb_q;
  reg [15:0] tick_cnt_q;
  reg us_tick_q;
  reg [1:0] seq_st_q;
  reg [16:0] seq_us_q;
  reg trig_q;
  reg shunt_convert_q;
  reg bus_convert_q;
  reg [15:0] rd_word;

  wire [7:0] rx_byte;
  wire rx_valid;
  wire tx_take;
  wire txn_end;
  wire [15:0] shunt_fmt;
  wire [7:0] tx_byte = rd_sel_q ? rd_lsb_q : rd_word[15:8];
  wire [2:0] mode = config_q[`CFG_MODE_HI:`CFG_MODE_LO];
  wire byte2 = rx_valid && wr_idx_q == `WR_IDX_LSB;
  wire settle_done = armed_q && settle_q == SETTLE_LAST;
  wire commit = stage_full_q && (settle_done || byte2);
  wire cfg_hit = commit && stage_ptr_q == `PTR_CONFIG;
  wire cfg_commit = cfg_hit && !stage_q[`CFG_RST_BIT];
  wire new_trig = !stage_q[`MODE_CONT_BIT] && (stage_q[`MODE_BUS_BIT] || stage_q[`MODE_SHUNT_BIT]);
  wire cal_zero = cal_q == `CAL_RESET;

  assign bus_range_select = config_q[`CFG_RANGE_BIT];
  assign shunt_gain_select = config_q[`CFG_GAIN_HI:`CFG_GAIN_LO];
  assign bus_conversion_setting = config_q[`CFG_BUS_CONVERSION_SETTING_HI:`CFG_BUS_CONVERSION_SETTING_LO];
  assign shunt_conversion_setting = config_q[`CFG_SHUNT_CONVERSION_SETTING_HI:`CFG_SHUNT_CONVERSION_SETTING_LO];
  assign operating_mode = mode;
  assign calibration_value = cal_q;
  assign shunt_convert = shunt_convert_q;
  assign bus_convert = bus_convert_q;

  i2c_target_port #(
    .TARGET_ADDR(TARGET_ADDR)
  ) u_port (
    .clk(clk),
    .sys_rst(sys_rst),
    .scl_pin(scl_pin),
    .sda_pin(sda_pin),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .rx_byte(rx_byte),
    .rx_valid(rx_valid),
    .tx_byte(tx_byte),
    .tx_take(tx_take),
    .txn_end(txn_end)
  );

  shunt_result_format u_fmt (
    .raw_sample(shunt_sample),
    .gain_select(config_q[`CFG_GAIN_HI:`CFG_GAIN_LO]),
    .formatted(shunt_fmt)
  );

  // write path: pointer byte, then msb, then lsb staged until it settles
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_q <= `PTR_CONFIG;
      wr_idx_q <= `WR_IDX_PTR;
      msb_q <= 8'h00;
      stage_q <= `RESULT_RESET;
      stage_ptr_q <= `PTR_CONFIG;
      stage_full_q <= 1'b0;
      armed_q <= 1'b0;
      settle_q <= 10'h000;
    end else if (soft_rst_q) begin
      ptr_q <= `PTR_CONFIG;
      wr_idx_q <= `WR_IDX_PTR;
      stage_full_q <= 1'b0;
      armed_q <= 1'b0;
      settle_q <= 10'h000;
    end else begin
      if (armed_q) begin
        settle_q <= settle_q + 10'h001;
      end
      if (commit) begin
        stage_full_q <= 1'b0;
        armed_q <= 1'b0;
      end
      if (txn_end) begin
        wr_idx_q <= `WR_IDX_PTR;
        if (stage_full_q && !armed_q) begin
          armed_q <= 1'b1;
          settle_q <= 10'h000;
        end
      end
      if (rx_valid) begin
        case (wr_idx_q)
          `WR_IDX_PTR: begin
            ptr_q <= rx_byte;
            wr_idx_q <= `WR_IDX_MSB;
          end
          `WR_IDX_MSB: begin
            msb_q <= rx_byte;
            wr_idx_q <= `WR_IDX_LSB;
          end
          `WR_IDX_LSB: begin
            // a second word before the first settles pushes the first out at once
            stage_q <= {msb_q, rx_byte};
            stage_ptr_q <= ptr_q;
            stage_full_q <= 1'b1;
            armed_q <= 1'b0;
            wr_idx_q <= `WR_IDX_DONE;
          end
          default: wr_idx_q <= `WR_IDX_DONE;
        endcase
      end
    end
  end

  // writable registers and the self-clearing full reset
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      config_q <= `CONFIG_RESET;
      cal_q <= `CAL_RESET;
      soft_rst_q <= 1'b0;
    end else if (soft_rst_q) begin
      config_q <= `CONFIG_RESET;
      cal_q <= `CAL_RESET;
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= cfg_hit && stage_q[`CFG_RST_BIT];
      if (cfg_commit) begin
        config_q <= stage_q;
      end
      if (commit && stage_ptr_q == `PTR_CAL) begin
        cal_q <= stage_q;
      end
      // result pointers fall through here with no effect
    end
  end

  // read word for the current pointer; the pointer is never advanced by reads
  always @* begin
    case (ptr_q)
      `PTR_CONFIG: rd_word = config_q;
      `PTR_SHUNT: rd_word = shunt_q;
      `PTR_BUS: rd_word = bus_q;
      `PTR_POWER: rd_word = cal_zero ? `RESULT_RESET : power_q;
      `PTR_CURRENT: rd_word = cal_zero ? `RESULT_RESET : current_q;
      `PTR_CAL: rd_word = cal_q;
      default: rd_word = `UNMAPPED_READ;
    endcase
  end

  // low byte is frozen when the high byte leaves, so a word never tears
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_sel_q <= 1'b0;
      rd_lsb_q <= 8'h00;
    end else if (txn_end) begin
      rd_sel_q <= 1'b0;
    end else if (tx_take) begin
      if (!rd_sel_q) begin
        rd_lsb_q <= rd_word[7:0];
      end
      rd_sel_q <= ~rd_sel_q;
    end
  end

  // one-microsecond enable for conversion timing
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_q <= 16'h0000;
      us_tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= 16'h0000;
      us_tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
      us_tick_q <= 1'b0;
    end
  end

  // conversion sequencer: shunt phase then bus phase, results latched at phase end
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_st_q <= SEQ_IDLE;
      seq_us_q <= 17'h00000;
      trig_q <= 1'b0;
      shunt_convert_q <= 1'b0;
      bus_convert_q <= 1'b0;
      shunt_q <= `RESULT_RESET;
      bus_q <= `RESULT_RESET;
      power_q <= `RESULT_RESET;
      current_q <= `RESULT_RESET;
    end else if (soft_rst_q) begin
      seq_st_q <= SEQ_IDLE;
      seq_us_q <= 17'h00000;
      trig_q <= 1'b0;
      shunt_convert_q <= 1'b0;
      bus_convert_q <= 1'b0;
      shunt_q <= `RESULT_RESET;
      bus_q <= `RESULT_RESET;
      power_q <= `RESULT_RESET;
      current_q <= `RESULT_RESET;
    end else if (cfg_commit) begin
      // new settings abort the running conversion and restart it unless the new mode is power-down or off
      seq_st_q <= SEQ_IDLE;
      shunt_convert_q <= 1'b0;
      bus_convert_q <= 1'b0;
      trig_q <= new_trig;
    end else begin
      case (seq_st_q)
        SEQ_IDLE: begin
          if (trig_q || (mode[`MODE_CONT_BIT] && mode[`MODE_BUS_BIT:`MODE_SHUNT_BIT] != 2'h0)) begin
            trig_q <= 1'b0;
            seq_us_q <= 17'h00000;
            if (mode[`MODE_SHUNT_BIT]) begin
              seq_st_q <= SEQ_SHUNT;
              shunt_convert_q <= 1'b1;
            end else begin
              seq_st_q <= SEQ_BUS;
              bus_convert_q <= 1'b1;
            end
          end
        end
        SEQ_SHUNT: begin
          if (us_tick_q && seq_us_q == conv_us(shunt_conversion_setting) - 17'h00001) begin
            shunt_q <= shunt_fmt;
            shunt_convert_q <= 1'b0;
            seq_us_q <= 17'h00000;
            if (mode[`MODE_BUS_BIT]) begin
              seq_st_q <= SEQ_BUS;
              bus_convert_q <= 1'b1;
            end else begin
              seq_st_q <= SEQ_IDLE;
              power_q <= cal_zero ? `RESULT_RESET : power_sample;
              current_q <= cal_zero ? `RESULT_RESET : current_sample;
            end
          end else if (us_tick_q) begin
            seq_us_q <= seq_us_q + 17'h00001;
          end
        end
        SEQ_BUS: begin
          if (us_tick_q && seq_us_q == conv_us(bus_conversion_setting) - 17'h00001) begin
            bus_q <= bus_sample;
            bus_convert_q <= 1'b0;
            seq_us_q <= 17'h00000;
            seq_st_q <= SEQ_IDLE;
            power_q <= cal_zero ? `RESULT_RESET : power_sample;
            current_q <= cal_zero ? `RESULT_RESET : current_sample;
          end else if (us_tick_q) begin
            seq_us_q <= seq_us_q + 17'h00001;
          end
        end
        default: seq_st_q <= SEQ_IDLE;
      endcase
    end
  end
endmodule

//--- tb/power_monitor_register_bank_properties.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ps
module power_monitor_register_bank_properties #(
  parameter US_TICK_CYCLES = 125
) (
  input wire clk,
  input wire sys_rst,
  input wire scl_pin,
  input wire sda_pin,
  input wire sda_out,
  input wire sda_oe_n,
  input wire bus_range_select,
  input wire [1:0] shunt_gain_select,
  input wire [3:0] bus_conversion_setting,
  input wire [3:0] shunt_conversion_setting,
  input wire [2:0] operating_mode,
  input wire [15:0] calibration_value,
  input wire shunt_convert,
  input wire bus_convert
);
  wire [15:0] cfg = {2'b00, bus_range_select, shunt_gain_select, bus_conversion_setting,
    shunt_conversion_setting, operating_mode};
  // only the four short codes are timed; the averaging ones run too long to watch
  wire [19:0] conv = 20'h14 + (20'h40 << shunt_conversion_setting[1:0]);
  reg scl_q;
  reg sda_q;
  reg [10:0] since_stop_q;
  reg [19:0] sh_cnt_q;
  // commit lands about 500 cycles after the stop is seen on the pins
  wire settle_win = since_stop_q >= 11'h1ef && since_stop_q <= 11'h208;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      since_stop_q <= 11'h7ff;
      sh_cnt_q <= 20'h0;
    end else begin
      scl_q <= scl_pin;
      sda_q <= sda_pin;
      if (scl_pin && scl_q && sda_pin && !sda_q)
        since_stop_q <= 11'h0;
      else if (since_stop_q != 11'h7ff)
        since_stop_q <= since_stop_q + 11'h1;
      sh_cnt_q <= shunt_convert ? sh_cnt_q + 20'h1 : 20'h0;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence mode_is(m);
    (operating_mode[1:0] == m) [*2];
  endsequence
  AST_RESET_CFG: assert property ($past(sys_rst) |-> cfg == 16'h399f && calibration_value == 16'h0)
    else $error("defaults wrong after reset");
  AST_CFG_SETTLE: assert property ($changed(cfg) |-> settle_win)
    else $error("configuration changed outside the settle point");
  AST_CAL_SETTLE: assert property ($changed(calibration_value) |-> settle_win)
    else $error("calibration changed outside the settle point");
  AST_IDLE_MODE: assert property (mode_is(2'b00) |=> !shunt_convert && !bus_convert)
    else $error("conversion while idle");
  AST_SHUNT_ONLY: assert property (mode_is(2'b01) |=> !bus_convert)
    else $error("bus conversion in shunt mode");
  AST_BUS_ONLY: assert property (mode_is(2'b10) |=> !shunt_convert)
    else $error("shunt conversion in bus mode");
  AST_NO_OVERLAP: assert property (!(shunt_convert && bus_convert))
    else $error("both phases at once");
  AST_SHUNT_LEN: assert property ($fell(shunt_convert) && !shunt_conversion_setting[3]
    && since_stop_q > 11'h212 |-> sh_cnt_q >= (conv - 20'h1) * US_TICK_CYCLES
    && sh_cnt_q <= conv * US_TICK_CYCLES + 2)
    else $error("shunt phase length wrong");
  AST_OPEN_DRAIN: assert property (!sda_oe_n |-> !sda_out)
    else $error("data driven high");
  AST_DATA_SCL_LOW: assert property ($changed(sda_oe_n) |-> !scl_pin)
    else $error("data changed while clock high");
endmodule

//--- tb/i2c_host_model.sv
// serial bus host model that writes and reads register words
`timescale 1ns/1ps
module i2c_host_model #(
  parameter [6:0] ADDR = 7'h40
) (
  input wire clk,
  input wire sda_out,
  input wire sda_oe_n,
  output reg scl_pin,
  output wire sda_pin,
  output reg [15:0] rd_data,
  output reg rd_done,
  output reg nack_seen
);
  reg sda_q;
  // pull-up wins unless a party pulls low
  assign sda_pin = sda_q & (sda_oe_n | sda_out);
  initial begin
    scl_pin = 1'b1;
    sda_q = 1'b1;
    rd_data = 16'h0;
    rd_done = 1'b0;
    nack_seen = 1'b0;
  end
  task wt(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // clock stands still between frames; one bit is 160 ns
  task bit_x(input b, output r);
    begin
      sda_q <= b;
      wt(5);
      scl_pin <= 1'b1;
      wt(5);
      r = sda_pin;
      wt(5);
      scl_pin <= 1'b0;
      wt(5);
    end
  endtask
  task start;
    begin
      sda_q <= 1'b1;
      wt(5);
      scl_pin <= 1'b1;
      wt(5);
      sda_q <= 1'b0;
      wt(5);
      scl_pin <= 1'b0;
      wt(5);
    end
  endtask
  task stop;
    begin
      sda_q <= 1'b0;
      wt(5);
      scl_pin <= 1'b1;
      wt(5);
      sda_q <= 1'b1;
      wt(5);
    end
  endtask
  task xfer(input [7:0] d, input rx, input last, output [7:0] q);
    reg a;
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_x(d[i], q[i]);
      bit_x(rx ? last : 1'b1, a);
      if (!rx && a)
        nack_seen = 1'b1;
    end
  endtask
  task write(input [7:0] ptr, input [15:0] d, input integer n);
    reg [7:0] q;
    integer i;
    begin
      start;
      xfer({ADDR, 1'b0}, 1'b0, 1'b0, q);
      xfer(ptr, 1'b0, 1'b0, q);
      for (i = 0; i < n; i = i + 1)
        xfer(d[15 - 8 * i -: 8], 1'b0, 1'b0, q);
      stop;
    end
  endtask
  task read;
    reg [7:0] hi;
    reg [7:0] lo;
    begin
      start;
      xfer({ADDR, 1'b1}, 1'b0, 1'b0, hi);
      xfer(8'hff, 1'b1, 1'b0, hi);
      xfer(8'hff, 1'b1, 1'b1, lo);
      stop;
      rd_data <= {hi, lo};
      rd_done <= 1'b1;
      wt(1);
      rd_done <= 1'b0;
    end
  endtask
endmodule

//--- tb/power_monitor_register_bank_bench.sv
// self-checking bench for the power monitor register bank
`timescale 1ns/1ps
module power_monitor_register_bank_bench;
  reg clk;
  reg sys_rst;
  reg [15:0] shunt_sample;
  reg [15:0] bus_sample;
  reg [15:0] current_sample;
  reg [15:0] power_sample;
  wire scl_pin;
  wire sda_pin;
  wire sda_out;
  wire sda_oe_n;
  wire bus_range_select;
  wire [1:0] shunt_gain_select;
  wire [3:0] bus_conversion_setting;
  wire [3:0] shunt_conversion_setting;
  wire [2:0] operating_mode;
  wire [15:0] calibration_value;
  wire shunt_convert;
  wire bus_convert;
  wire [15:0] rd_data;
  wire rd_done;
  wire nack_seen;
  wire [15:0] cfg_view = {2'b00, bus_range_select, shunt_gain_select, bus_conversion_setting,
    shunt_conversion_setting, operating_mode};
  logic [15:0] exp_q[$];
  int err_total;
  int check_count;
  int i;
  int g;
  int k;
  logic [15:0] cfg;
  logic [15:0] prev;
  logic [15:0] v;
  power_monitor_register_bank #(.US_TICK_CYCLES(2)) DUT (.clk(clk), .sys_rst(sys_rst), .scl_pin(scl_pin),
    .sda_pin(sda_pin), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .shunt_sample(shunt_sample),
    .bus_sample(bus_sample), .current_sample(current_sample), .power_sample(power_sample),
    .bus_range_select(bus_range_select), .shunt_gain_select(shunt_gain_select),
    .bus_conversion_setting(bus_conversion_setting), .shunt_conversion_setting(shunt_conversion_setting),
    .operating_mode(operating_mode), .calibration_value(calibration_value),
    .shunt_convert(shunt_convert), .bus_convert(bus_convert));
  i2c_host_model host (.clk(clk), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl_pin(scl_pin),
    .sda_pin(sda_pin), .rd_data(rd_data), .rd_done(rd_done), .nack_seen(nack_seen));
  always #4 clk = ~clk;
  task automatic check(input [15:0] seen, input [15:0] expv, input string what);
    check_count++;
    if (seen !== expv) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task rd_again(input [15:0] e);
    exp_q.push_back(e);
    host.read;
  endtask
  task rd(input [7:0] p, input [15:0] e);
    host.write(p, 16'h0, 0);
    rd_again(e);
  endtask
  task wr(input [7:0] p, input [15:0] d);
    host.write(p, d, 2);
    wt(520);
  endtask
  task wait_fall;
    int n;
    for (n = 0; n < 3000 && shunt_convert !== 1'b0; n++)
      wt(1);
    if (n == 3000) begin
      err_total++;
      complete_run;
    end
  endtask
  // the oldest note pairs with each word the host finishes reading
  always @(posedge clk) begin
    if (rd_done === 1'b1)
      check(rd_data, exp_q.pop_front(), "read word");
  end
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    shunt_sample = 16'h0;
    bus_sample = 16'h0;
    current_sample = 16'h0;
    power_sample = 16'h0;
    err_total = 0;
    check_count = 0;
    void'($urandom(40462));
    wt(12);
    sys_rst <= 1'b0;
    bus_sample <= 16'($urandom);
    current_sample <= 16'($urandom) | 16'h1;
    power_sample <= 16'($urandom) | 16'h1;
    wt(4);
    check(cfg_view, 16'h399f, "config outputs");
    rd(8'h00, 16'h399f);
    rd(8'h05, 16'h0000);
    rd(8'h03, 16'h0000);
    rd(8'h04, 16'h0000);
    rd(8'h06, 16'h0000);
    $display("reset values done");
    prev = 16'h399f;
    for (i = 0; i < 16; i++) begin
      cfg = {2'b00, i[0], i[2:1], i[3:0], ~i[3:0], 3'b100};
      host.write(8'h00, cfg, 2);
      wt(450);
      check(cfg_view, prev, "config before settle");
      wt(70);
      check(cfg_view, cfg, "config after settle");
      rd_again(cfg);
      prev = cfg;
    end
    $display("config fields done");
    v = 16'($urandom) | 16'h1;
    wr(8'h05, v);
    check(calibration_value, v, "calibration output");
    rd_again(v);
    wr(8'h00, 16'h0007);
    wt(1000);
    for (i = 1; i < 5; i++) begin
      v = (i == 1) ? 16'h0 : (i == 2) ? bus_sample : (i == 3) ? power_sample : current_sample;
      wr(i[7:0], ~v);
      rd_again(v);
    end
    $display("result registers done");
    for (g = 0; g < 4; g++) begin
      for (k = 0; k < 3; k++) begin
        v = 16'($urandom_range(7999)) - 16'hfa0;
        shunt_sample <= (k == 0) ? 16'h7fff : (k == 1) ? 16'h8000 : v;
        cfg = {3'b000, g[1:0], 8'h00, g[0], k == 1, 1'b1};
        wr(8'h00, cfg);
        wait_fall;
        v = (k == 0) ? 16'(4000 << g) : (k == 1) ? 16'(-(4000 << g)) : v;
        rd(8'h01, v);
      end
    end
    for (i = 0; i < 3; i++) begin
      cfg = (i == 0) ? 16'h0000 : {13'h0, i[0], 2'b10};
      wr(8'h00, cfg);
      wt(600);
      check({15'h0, shunt_convert}, 16'h0, "shunt phase idle");
    end
    $display("shunt format and modes done");
    wr(8'h00, 16'h8c47);
    check(cfg_view, 16'h399f, "config after soft reset");
    check(calibration_value, 16'h0000, "calibration after soft reset");
    rd(8'h00, 16'h399f);
    check({15'h0, nack_seen}, 16'h0, "acknowledges");
    wt(2);
    check(16'(exp_q.size()), 16'h0, "reads outstanding");
    $display("soft reset done");
    complete_run;
  end
endmodule
bind power_monitor_register_bank power_monitor_register_bank_properties #(.US_TICK_CYCLES(US_TICK_CYCLES)) chk (
  .clk(clk), .sys_rst(sys_rst), .scl_pin(scl_pin), .sda_pin(sda_pin), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .bus_range_select(bus_range_select), .shunt_gain_select(shunt_gain_select),
  .bus_conversion_setting(bus_conversion_setting), .shunt_conversion_setting(shunt_conversion_setting),
  .operating_mode(operating_mode), .calibration_value(calibration_value),
  .shunt_convert(shunt_convert), .bus_convert(bus_convert));
